// [logic/sdv_volume.sv]
// Two-channel digital volume stage with register map and silence detection
// Summary of operation
// [RL1] Left write without apply flag stores code; applied gain untouched.
// [RL2] Left write with apply flag stores code, applies both stored codes together.
// [RL3] Right write without apply flag stores code; applied gain untouched.
// [RL4] Right write with apply flag stores code, applies both stored codes together.
// [RL5] Code zero is -100dB; each code step adds a quarter decibel.
// [RL6] Left gain resets to 0dB code, apply flag reads zero.
// [RL7] Right gain resets to 0dB code, apply flag reads zero.
// [RL8] Codes with top three bits set saturate at +12dB.
// [RL9] Silence select bit picks 1024 samples when clear, 2048 when set.
// [RL10] Silence flagged after run of zero samples, cleared by first non-zero.
// [RL11] Rise ramp enabled steps increases gradually, else immediate.
// [RL12] Fall ramp enabled steps decreases gradually, else immediate.
// [RL13] Zero-cross wait defers gain changes to a zero crossing.
`timescale 1ns/1ps
`default_nettype none
module sdv_volume
    import sdv_pkg::*;
#(
    parameter int SAMPLE_W = SDV_SAMPLE_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port from the control interface
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [9:0] reg_wdata_i,
    output logic [9:0] reg_rdata_o,
    // Gain change behaviour settings
    input wire logic gain_rise_ramp_en_i,
    input wire logic gain_fall_ramp_en_i,
    input wire logic zero_crossing_wait_en_i,
    // Audio samples
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] left_sample_i,
    input wire logic [SAMPLE_W-1:0] right_sample_i,
    // Applied gain and silence status
    output logic [8:0] left_applied_gain_o,
    output logic [8:0] right_applied_gain_o,
    output logic left_silent_o,
    output logic right_silent_o
);

    // Register map state
    logic [8:0] left_gain_code;
    logic [8:0] right_gain_code;
    logic left_apply_both;
    logic right_apply_both;
    logic silence_run_select;

    // Gain targets and applied gains per channel
    logic [SDV_CHANNELS-1:0][8:0] target;
    logic [SDV_CHANNELS-1:0][8:0] applied;
    logic [SDV_CHANNELS-1:0] silent;
    logic [SDV_CHANNELS-1:0][SAMPLE_W-1:0] samples;
    logic [6:0] rd_addr;
    logic [9:0] next_rdata;

    logic wr_left;
    logic wr_right;
    logic apply_now;
    logic [8:0] apply_left;
    logic [8:0] apply_right;
    logic [SDV_RUN_W-1:0] run_limit;

    // Saturate the top of the range onto the ceiling step
    function automatic logic [8:0] sdv_sat(input logic [8:0] code);
        logic [8:0] res;
        res = code;
        if (code[8:6] == SDV_SAT_TOP) begin // RL8
            res = SDV_CODE_CEIL;
        end
        return res;
    endfunction : sdv_sat

    assign rd_addr = reg_addr_i;
    assign wr_left = reg_wr_i && (reg_addr_i == SDV_LEFT_GAIN_OFS);
    assign wr_right = reg_wr_i && (reg_addr_i == SDV_RIGHT_GAIN_OFS);
    assign apply_now = (wr_left || wr_right) && reg_wdata_i[SDV_APPLY_BIT]; // RL2 RL4
    // A write that applies uses its own new code for its own channel
    assign apply_left = wr_left ? reg_wdata_i[SDV_CODE_MSB:0] : left_gain_code;
    assign apply_right = wr_right ? reg_wdata_i[SDV_CODE_MSB:0] : right_gain_code;
    // Silence run length follows the select bit
    assign run_limit = silence_run_select ? SDV_RUN_W'(SDV_RUN_LONG)
                                          : SDV_RUN_W'(SDV_RUN_SHORT); // RL9
    assign samples[0] = left_sample_i;
    assign samples[1] = right_sample_i;

    // Left gain register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            left_gain_code <= SDV_CODE_RST; // RL6
            left_apply_both <= SDV_APPLY_RST; // RL6
        end else if (wr_left) begin
            left_gain_code <= reg_wdata_i[SDV_CODE_MSB:0]; // RL1
            left_apply_both <= reg_wdata_i[SDV_APPLY_BIT];
        end
    end

    // Right gain register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            right_gain_code <= SDV_CODE_RST; // RL7
            right_apply_both <= SDV_APPLY_RST; // RL7
        end else if (wr_right) begin
            right_gain_code <= reg_wdata_i[SDV_CODE_MSB:0]; // RL3
            right_apply_both <= reg_wdata_i[SDV_APPLY_BIT];
        end
    end

    // Silence run select register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            silence_run_select <= SDV_SILENCE_RST;
        end else if (reg_wr_i && (reg_addr_i == SDV_SILENCE_OFS)) begin
            silence_run_select <= reg_wdata_i[SDV_SILENCE_BIT];
        end
    end

    // Targets move only on an applying write, both channels at once
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            target[0] <= SDV_CODE_RST;
            target[1] <= SDV_CODE_RST;
        end else if (apply_now) begin
            target[0] <= sdv_sat(apply_left); // RL2 RL4
            target[1] <= sdv_sat(apply_right); // RL2 RL4
        end
    end

    // Read-back, registered; unmapped offsets read zero
    always_comb begin
        next_rdata = 10'h000;
        unique case (rd_addr)
            SDV_LEFT_GAIN_OFS: next_rdata = {left_apply_both, left_gain_code};
            SDV_RIGHT_GAIN_OFS: next_rdata = {right_apply_both, right_gain_code};
            SDV_SILENCE_OFS: next_rdata = {9'h000, silence_run_select};
            default: next_rdata = 10'h000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 10'h000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Per-channel gain tracking and silence detection
    for (genvar ch = 0; ch < SDV_CHANNELS; ch++) begin : g_chan
        logic prev_sign;
        logic crossing;
        logic is_zero;
        logic [SDV_RUN_W-1:0] zero_run;

        assign is_zero = (samples[ch] == '0);
        // A zero sample or a sign flip against the last valid sample
        assign crossing = is_zero || (samples[ch][SAMPLE_W-1] != prev_sign);

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                prev_sign <= 1'b0;
            end else if (sample_valid_i) begin
                // Only valid samples move the reference sign
                prev_sign <= samples[ch][SAMPLE_W-1];
            end
        end

        // Applied code steps one quarter decibel per sample when ramping
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                applied[ch] <= SDV_CODE_RST;
            end else if (sample_valid_i && (!zero_crossing_wait_en_i || crossing)) begin // RL13
                if (target[ch] > applied[ch]) begin
                    if (gain_rise_ramp_en_i) begin
                        applied[ch] <= applied[ch] + 9'h001; // RL11 RL5
                    end else begin
                        applied[ch] <= target[ch]; // RL11
                    end
                end else if (target[ch] < applied[ch]) begin
                    if (gain_fall_ramp_en_i) begin
                        applied[ch] <= applied[ch] - 9'h001; // RL12 RL5
                    end else begin
                        applied[ch] <= target[ch]; // RL12
                    end
                end
            end
        end

        // Count consecutive zero samples, saturating at the limit
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                zero_run <= '0;
                silent[ch] <= 1'b0;
            end else if (sample_valid_i) begin
                if (!is_zero) begin
                    zero_run <= '0; // RL10
                    silent[ch] <= 1'b0; // RL10
                end else if (zero_run + SDV_RUN_W'(1) >= run_limit) begin
                    zero_run <= run_limit;
                    silent[ch] <= 1'b1; // RL10
                end else begin
                    // Below the limit, e.g. after the limit was raised mid-run
                    zero_run <= zero_run + SDV_RUN_W'(1);
                    silent[ch] <= 1'b0; // RL10
                end
            end
        end
    end

    // Outputs are the channel flops themselves
    assign left_applied_gain_o = applied[0];
    assign right_applied_gain_o = applied[1];
    assign left_silent_o = silent[0];
    assign right_silent_o = silent[1];

endmodule : sdv_volume
`default_nettype wire

// [include/sdv_pkg.sv]
// Package: register map, field layout, reset values and counts for the volume block
package sdv_pkg;
    // Register offsets
    localparam logic [6:0] SDV_LEFT_GAIN_OFS = 7'h06;
    localparam logic [6:0] SDV_RIGHT_GAIN_OFS = 7'h07;
    localparam logic [6:0] SDV_SILENCE_OFS = 7'h08;
    // Field positions
    localparam int SDV_APPLY_BIT = 9;
    localparam int SDV_CODE_MSB = 8;
    localparam int SDV_SILENCE_BIT = 0;
    // Widths
    localparam int SDV_CODE_W = 9;
    localparam int SDV_REG_W = 10;
    localparam int SDV_SAMPLE_W = 24;
    localparam int SDV_CHANNELS = 2;
    // Reset values
    localparam logic [8:0] SDV_CODE_RST = 9'h190;
    localparam logic SDV_APPLY_RST = 1'b0;
    localparam logic SDV_SILENCE_RST = 1'b0;
    // Saturation: top three bits set means the ceiling step
    localparam logic [2:0] SDV_SAT_TOP = 3'h7;
    localparam logic [8:0] SDV_CODE_CEIL = 9'h1c0;
    // Silence run lengths in samples
    localparam int SDV_RUN_SHORT = 1024;
    localparam int SDV_RUN_LONG = 2048;
    localparam int SDV_RUN_W = 12;
endpackage : sdv_pkg

// [sim/sdv_volume_chk.sv]
// Port checks for the volume block
`timescale 1ns/1ps
`default_nettype none
module sdv_volume_chk
    import sdv_pkg::*;
#(
    parameter int SAMPLE_W = SDV_SAMPLE_W
) (
    // Clock, reset, registers
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic [9:0] reg_wdata_i,
    input wire logic [9:0] reg_rdata_o,
    // Settings and samples
    input wire logic gain_rise_ramp_en_i,
    input wire logic gain_fall_ramp_en_i,
    input wire logic sample_valid_i,
    input wire logic [SAMPLE_W-1:0] left_sample_i,
    input wire logic [SAMPLE_W-1:0] right_sample_i,
    // Status
    input wire logic [8:0] left_applied_gain_o,
    input wire logic [8:0] right_applied_gain_o,
    input wire logic left_silent_o,
    input wire logic right_silent_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    left_hold_a: assert property (!sample_valid_i |=> $stable(left_applied_gain_o))
        else $error("left gain moved with no sample");
    right_hold_a: assert property (!sample_valid_i |=> $stable(right_applied_gain_o))
        else $error("right gain moved with no sample");
    rise_step_a: assert property (sample_valid_i && gain_rise_ramp_en_i |=>
        left_applied_gain_o <= $past(left_applied_gain_o) + 9'h001)
        else $error("left rise above one step");
    fall_step_a: assert property (sample_valid_i && gain_fall_ramp_en_i |=>
        right_applied_gain_o + 9'h001 >= $past(right_applied_gain_o))
        else $error("right fall above one step");
    gain_ceil_a: assert property (left_applied_gain_o <= SDV_CODE_CEIL &&
        right_applied_gain_o <= SDV_CODE_CEIL) else $error("applied gain above ceiling");
    left_quiet_a: assert property (sample_valid_i && left_sample_i != '0 |=>
        !left_silent_o) else $error("left silent after non-zero sample");
    right_quiet_a: assert property (sample_valid_i && right_sample_i != '0 |=>
        !right_silent_o) else $error("right silent after non-zero sample");
    store_back_a: assert property (reg_wr_i && reg_addr_i == SDV_LEFT_GAIN_OFS ##1
        !reg_wr_i ##1 reg_rd_i && !reg_wr_i && reg_addr_i == SDV_LEFT_GAIN_OFS
        |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("left readback differs");
endmodule : sdv_volume_chk
bind sdv_volume sdv_volume_chk #(.SAMPLE_W(SAMPLE_W)) i_chk (.clk_i, .rst_n_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .gain_rise_ramp_en_i,
    .gain_fall_ramp_en_i, .sample_valid_i, .left_sample_i, .right_sample_i,
    .left_applied_gain_o, .right_applied_gain_o, .left_silent_o, .right_silent_o);
`default_nettype wire

// [sim/sdv_volume_bench.sv]
// Directed bench for the volume block
`timescale 1ns/1ps
`default_nettype none
module sdv_volume_bench
    import sdv_pkg::*;
;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, sv = 1'b0, rise = 1'b0, fall = 1'b0;
    logic zc = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [9:0] wdata = 10'h000, rdata;
    logic [23:0] ls = 24'h000000, rs = 24'h000000;
    logic [8:0] lg, rg;
    logic lz, rz;
    int num_errors = 0, tests_run = 0, cyc = 0;
    initial forever #12.5 clk_i = ~clk_i;
    sdv_volume i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .gain_rise_ramp_en_i(rise), .gain_fall_ramp_en_i(fall), .zero_crossing_wait_en_i(zc),
        .sample_valid_i(sv), .left_sample_i(ls), .right_sample_i(rs), .left_applied_gain_o(lg),
        .right_applied_gain_o(rg), .left_silent_o(lz), .right_silent_o(rz));
    task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wreg(input logic [6:0] a, input logic [9:0] d);
        @(negedge clk_i) {wr, addr, wdata} <= {1'b1, a, d};
        @(negedge clk_i) wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [6:0] a, input logic [9:0] e);
        @(negedge clk_i) {rd, addr} <= {1'b1, a};
        @(negedge clk_i) rd <= 1'b0;
        chk("read data", rdata, e);
    endtask : rreg
    task automatic smp(input logic [23:0] l, input logic [23:0] r);
        @(negedge clk_i) {sv, ls, rs} <= {1'b1, l, r};
        @(negedge clk_i) sv <= 1'b0;
    endtask : smp
    task automatic gains(input logic [8:0] l, input logic [8:0] r);
        chk("left gain", lg, l);
        chk("right gain", rg, r);
    endtask : gains
    task automatic end_sim;
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i <= 1'b1;
        gains(9'h190, 9'h190);
        rreg(SDV_LEFT_GAIN_OFS, 10'h190);
        rreg(SDV_RIGHT_GAIN_OFS, 10'h190);
        rreg(SDV_SILENCE_OFS, 10'h000);
        rreg(7'h09, 10'h000);
        wreg(SDV_LEFT_GAIN_OFS, 10'h050);
        rreg(SDV_LEFT_GAIN_OFS, 10'h050);
        smp(24'h1, 24'h1);
        gains(9'h190, 9'h190);
        wreg(SDV_RIGHT_GAIN_OFS, 10'h3c5);
        rreg(SDV_RIGHT_GAIN_OFS, 10'h3c5);
        smp(24'h1, 24'h1);
        gains(9'h050, 9'h1c0);
        wreg(SDV_RIGHT_GAIN_OFS, 10'h0a0);
        smp(24'h1, 24'h1);
        gains(9'h050, 9'h1c0);
        wreg(SDV_LEFT_GAIN_OFS, 10'h201);
        smp(24'h1, 24'h1);
        gains(9'h001, 9'h0a0);
        rise <= 1'b1;
        wreg(SDV_LEFT_GAIN_OFS, 10'h203);
        smp(24'h1, 24'h1);
        gains(9'h002, 9'h0a0);
        smp(24'h1, 24'h1);
        gains(9'h003, 9'h0a0);
        fall <= 1'b1;
        wreg(SDV_RIGHT_GAIN_OFS, 10'h29e);
        smp(24'h1, 24'h1);
        gains(9'h003, 9'h09f);
        repeat (1023) smp(24'h0, 24'h1);
        chk("left silent", lz, 1'b0);
        smp(24'h0, 24'h1);
        chk("left silent", lz, 1'b1);
        chk("right silent", rz, 1'b0);
        smp(24'h5, 24'h5);
        chk("left silent", lz, 1'b0);
        wreg(SDV_SILENCE_OFS, 10'h001);
        rreg(SDV_SILENCE_OFS, 10'h001);
        repeat (2047) smp(24'h0, 24'h0);
        chk("right silent", rz, 1'b0);
        smp(24'h0, 24'h0);
        chk("left silent", lz, 1'b1);
        chk("right silent", rz, 1'b1);
        gains(9'h003, 9'h09e);
        zc <= 1'b1;
        rise <= 1'b0;
        wreg(SDV_LEFT_GAIN_OFS, 10'h210);
        smp(24'h5, 24'h5);
        gains(9'h003, 9'h09e);
        smp(24'hfffffb, 24'h5);
        gains(9'h010, 9'h09e);
        end_sim();
    end
endmodule : sdv_volume_bench
`default_nettype wire
